//--- lst_defs.vh
// Purpose: constants for the line scan trigger sequencer
// Assumes: 250 MHz core clock
// Notes: activation codes shared by frame and line trigger settings
`ifndef LST_DEFS_VH
`define LST_DEFS_VH
`define LST_CLK_MHZ 250
`define LST_MIN_PULSE_US 1
`define LST_MIN_PULSE_CYC (`LST_MIN_PULSE_US * `LST_CLK_MHZ)
`define LST_ACT_RISE 3'h0
`define LST_ACT_FALL 3'h1
`define LST_ACT_ANY 3'h2
`define LST_ACT_HIGH 3'h3
`define LST_ACT_LOW 3'h4
`define LST_SEL_FRAME 1'b0
`define LST_SEL_LINE 1'b1
`define LST_HEIGHT_RST 16'h0001
`define LST_PERIOD_RST 32'h000009C4
`define LST_ACT_RST 3'h0
`define LST_GLITCH_W 9
`endif

//--- lst_input_filter.v
// Purpose: synchronise one trigger pin and reject short pulses
// Assumes: pin is asynchronous to core_clk
// Notes: filtered level changes only after a stable run of the minimum width
`timescale 1ns/1ns
`include "lst_defs.vh"
module lst_input_filter (
    input wire core_clk, // clock
    input wire rst_n, // async reset, active low
    input wire pin, // raw trigger pin
    output reg level, // filtered level
    output reg rise, // one-cycle rising pulse
    output reg fall // one-cycle falling pulse
);
    reg sync_a;
    reg sync_b;
    reg [`LST_GLITCH_W-1:0] run;
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            run <= {`LST_GLITCH_W{1'b0}};
            level <= 1'b0;
            rise <= 1'b0;
            fall <= 1'b0;
        end else begin
            sync_a <= pin; // see R20
            sync_b <= sync_a; // see R20
            rise <= 1'b0;
            fall <= 1'b0;
            if (sync_b == level) begin
                run <= {`LST_GLITCH_W{1'b0}};
            end else if (run == `LST_MIN_PULSE_CYC - 1) begin
                run <= {`LST_GLITCH_W{1'b0}};
                level <= sync_b; // see R19
                rise <= sync_b;
                fall <= ~sync_b;
            end else begin
                run <= run + 1'b1; // see R19
            end
        end
    end
endmodule // lst_input_filter

//--- lst_line_timer.v
// Purpose: internal line trigger generator
// Assumes: periods in core_clk cycles, nonzero
// Notes: slower of configured and minimum period wins
`timescale 1ns/1ns
`include "lst_defs.vh"
module lst_line_timer (
    input wire core_clk, // clock
    input wire rst_n, // async reset, active low
    input wire run, // generate while high
    input wire [31:0] cfg_period, // requested line period
    input wire [31:0] min_period, // period at maximum rate
    output reg tick // one-cycle internal trigger
);
    reg [31:0] cnt;
    wire [31:0] eff_period;
    assign eff_period = (cfg_period > min_period) ? cfg_period : min_period; // see R16
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 32'h00000000;
            tick <= 1'b0;
        end else if (!run) begin
            cnt <= 32'h00000000;
            tick <= 1'b0;
        end else if (cnt == 32'h00000000) begin
            tick <= 1'b1; // see R15
            cnt <= (eff_period > 32'h00000001) ? eff_period - 32'h00000001 : 32'h00000000;
        end else begin
            tick <= 1'b0;
            cnt <= cnt - 32'h00000001;
        end
    end
endmodule // lst_line_timer

//--- lst_trigger_ctrl.v
// Purpose: acquisition arm, frame window and line trigger sequencer
// Assumes: settings from logic on core_clk; pins asynchronous
// Notes: settings load through a selector-addressed write strobe
`timescale 1ns/1ns
`include "lst_defs.vh"

// Contract
// R1: no acquisition before a start command
// R2: start arms continuously until stop
// R3: stop disarms until next start
// R4: line triggers outside frame window are dropped
// R5: selector steers mode, source, activation writes
// R6: frame mode off opens window at start
// R7: edge or internal window closes after frame
// R8: frame line count equals height setting
// R9: internal mode reopens window until stop
// R10: frame mode on uses selected input
// R11: edge activation opens on chosen edge
// R12: level high opens rising, closes low
// R13: level low opens falling, closes high
// R14: each accepted trigger starts one line
// R15: internal line triggers from start to stop
// R16: internal rate clamped to maximum rate
// R17: external line edges act as triggers
// R18: source keeps below maximum line rate
// R19: pulses under one microsecond are ignored
// R20: inputs synchronised before edge detection
module lst_trigger_ctrl (
    input wire core_clk, // clock
    input wire rst_n, // async reset, active low
    input wire external_trigger_input_a, // trigger pin a
    input wire external_trigger_input_b, // trigger pin b
    input wire acq_start, // start command pulse
    input wire acq_stop, // stop command pulse
    input wire trig_wr, // write strobe for trigger settings
    input wire trig_selector, // 0 frame, 1 line
    input wire wr_mode, // trigger mode on
    input wire wr_source, // external_trigger_input_select
    input wire [2:0] wr_activation, // activation code
    input wire [15:0] height, // lines per frame
    input wire [31:0] line_period, // requested line period, cycles
    input wire [31:0] min_line_period, // period at max allowed rate
    output reg armed, // acquisition armed
    output reg frame_valid, // frame window open
    output reg line_start, // one-cycle line acquisition pulse
    output reg frame_done, // one-cycle frame complete pulse
    output reg frame_mode, // frame trigger mode readback
    output reg line_mode, // line trigger mode readback
    output reg [15:0] line_count // lines taken in this frame
);
    // ****************************************
    // frame window states, one-hot
    // ****************************************
    localparam ST_IDLE = 3'h1;
    localparam ST_WAIT = 3'h2;
    localparam ST_OPEN = 3'h4;

    reg [2:0] state;
    reg [2:0] next_state;
    reg frame_src;
    reg [2:0] frame_act;
    reg line_src;
    reg [2:0] line_act;
    // filtered pin levels and one-cycle edges
    wire lvl_a;
    wire rise_a;
    wire fall_a;
    wire lvl_b;
    wire rise_b;
    wire fall_b;
    wire int_tick;

    // ****************************************
    // input conditioning
    // ****************************************
    // two flops then a stable run of one microsecond
    lst_input_filter u_filt_a (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .pin(external_trigger_input_a),
        .level(lvl_a),
        .rise(rise_a),
        .fall(fall_a)
    );
    lst_input_filter u_filt_b (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .pin(external_trigger_input_b),
        .level(lvl_b),
        .rise(rise_b),
        .fall(fall_b)
    );

    // edge match against an activation code
    function edge_hit;
        input [2:0] act;
        input r;
        input f;
        begin
            case (act)
                `LST_ACT_RISE: edge_hit = r;
                `LST_ACT_FALL: edge_hit = f;
                `LST_ACT_ANY: edge_hit = r | f;
                `LST_ACT_HIGH: edge_hit = r;
                `LST_ACT_LOW: edge_hit = f;
                default: edge_hit = 1'b0;
            endcase
        end
    endfunction

    // pick the pin chosen by a source setting
    function pick;
        input src;
        input from_a;
        input from_b;
        begin
            if (src) begin
                pick = from_b;
            end else begin
                pick = from_a;
            end
        end
    endfunction

    // level codes hold the window by pin level
    function level_act;
        input [2:0] act;
        begin
            case (act)
                `LST_ACT_HIGH: level_act = 1'b1;
                `LST_ACT_LOW: level_act = 1'b1;
                default: level_act = 1'b0;
            endcase
        end
    endfunction

    // ****************************************
    // trigger settings
    // ****************************************
    // selector steers each write to one set
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_mode <= 1'b0;
            frame_src <= 1'b0;
            frame_act <= `LST_ACT_RST;
        end else if (trig_wr && (trig_selector == `LST_SEL_FRAME)) begin
            frame_mode <= wr_mode; // see R5
            frame_src <= wr_source;
            frame_act <= wr_activation;
        end
    end

    // level codes make no sense for lines: they fall back to rising
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            line_mode <= 1'b0;
            line_src <= 1'b0;
            line_act <= `LST_ACT_RST;
        end else if (trig_wr && (trig_selector == `LST_SEL_LINE)) begin
            line_mode <= wr_mode; // see R5
            line_src <= wr_source;
            line_act <= (wr_activation > `LST_ACT_ANY) ? `LST_ACT_RISE : wr_activation;
        end
    end

    // ****************************************
    // frame trigger sources
    // ****************************************
    wire f_rise = pick(frame_src, rise_a, rise_b); // see R10
    wire f_fall = pick(frame_src, fall_a, fall_b);
    wire f_lvl = pick(frame_src, lvl_a, lvl_b);
    wire f_level_mode = level_act(frame_act);
    wire f_open_ev = edge_hit(frame_act, f_rise, f_fall); // see R11
    wire f_level_end = (frame_act == `LST_ACT_HIGH) ? ~f_lvl : f_lvl; // see R12 see R13

    // ****************************************
    // line trigger path
    // ****************************************
    wire l_rise = pick(line_src, rise_a, rise_b);
    wire l_fall = pick(line_src, fall_a, fall_b);
    wire ext_line = edge_hit(line_act, l_rise, l_fall); // see R17
    reg line_trig;
    reg take_line;
    reg last_line;
    // line triggers count only inside an open window
    always @* begin
        line_trig = int_tick;
        if (line_mode) begin
            line_trig = ext_line;
        end
        take_line = 1'b0;
        if ((state == ST_OPEN) && line_trig && !acq_stop) begin
            take_line = 1'b1; // see R4 see R14
        end
        last_line = 1'b0;
        if (take_line && !(frame_mode && f_level_mode)) begin
            last_line = (line_count + 16'h0001 >= height); // see R7 see R8
        end
    end

    // ****************************************
    // internal line timer
    // ****************************************
    lst_line_timer u_timer (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .run(armed && !line_mode), // see R15
        .cfg_period(line_period),
        .min_period(min_line_period),
        .tick(int_tick)
    );

    // ****************************************
    // frame window state machine
    // ****************************************
    always @* begin
        next_state = state;
        case (state)
            // nothing moves until a start
            ST_IDLE: begin
                if (acq_start) begin // see R1
                    next_state = ST_WAIT;
                end
            end
            // internal frames reopen after one cycle here
            ST_WAIT: begin
                if (acq_stop) begin
                    next_state = ST_IDLE; // see R3
                end else if (!frame_mode) begin
                    next_state = ST_OPEN; // see R6 see R9
                end else if (f_open_ev) begin
                    next_state = ST_OPEN; // see R10
                end
            end
            // stop closes the window and pulses done
            ST_OPEN: begin
                if (acq_stop) begin
                    next_state = ST_IDLE; // see R3
                end else if (frame_mode && f_level_mode && f_level_end) begin
                    next_state = ST_WAIT; // see R12 see R13
                end else if (last_line) begin
                    next_state = ST_WAIT; // see R7
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // ****************************************
    // window state and arm flag
    // ****************************************
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // stop wins over a start in the same cycle
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            armed <= 1'b0;
        end else if (acq_stop) begin
            armed <= 1'b0; // see R3
        end else if (acq_start) begin
            armed <= 1'b1; // see R2
        end
    end

    // ****************************************
    // registered window and line outputs
    // ****************************************
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_valid <= 1'b0;
            frame_done <= 1'b0;
        end else begin
            frame_valid <= (next_state == ST_OPEN);
            frame_done <= (state == ST_OPEN) && (next_state != ST_OPEN);
        end
    end

    // accepted trigger becomes a one-cycle line pulse
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            line_start <= 1'b0;
        end else begin
            line_start <= take_line; // see R14
        end
    end

    // count restarts whenever the window is not held open
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            line_count <= 16'h0000;
        end else if (next_state != ST_OPEN) begin
            line_count <= 16'h0000;
        end else if (take_line) begin
            line_count <= line_count + 16'h0001; // see R8
        end
    end
endmodule // lst_trigger_ctrl

//--- lst_pin_src.sv
// Purpose: external trigger source model driving both pins
// Assumes: bench calls drive with a hold time in core_clk cycles
// Notes: pins are always driven, no release state
`timescale 1ns/1ns
module lst_pin_src (
    input wire core_clk, // clock
    output reg pin_a, // trigger pin a
    output reg pin_b // trigger pin b
);
    initial begin
        pin_a = 1'b0;
        pin_b = 1'b0;
    end
    // holds of 250 or more keep pulses valid and the rate legal
    task drive(input sel, input val, input integer hold);
        begin
            @(negedge core_clk);
            if (sel)
                pin_b = val;
            else
                pin_a = val;
            repeat (hold) @(negedge core_clk);
        end
    endtask
endmodule // lst_pin_src

//--- lst_trigger_monitor.sv
// Purpose: port checker for the trigger sequencer
// Assumes: one clock domain, async active-low reset
// Notes: bound to the lst_trigger_ctrl module
`timescale 1ns/1ns
module lst_trigger_monitor (
    input wire core_clk, // clock
    input wire rst_n, // async reset, active low
    input wire acq_start, // start pulse
    input wire acq_stop, // stop pulse
    input wire trig_wr, // settings strobe
    input wire trig_selector, // settings target
    input wire wr_mode, // mode to write
    input wire wr_source, // source to write
    input wire external_trigger_input_a, // pin a
    input wire external_trigger_input_b, // pin b
    input wire [2:0] wr_activation, // activation
    input wire [15:0] height, // lines per frame
    input wire [31:0] line_period, // requested period
    input wire [31:0] min_line_period, // period at max rate
    input wire armed, // acquisition armed
    input wire frame_valid, // window open
    input wire line_start, // line pulse
    input wire frame_done, // window closed pulse
    input wire frame_mode, // frame mode readback
    input wire line_mode, // line mode readback
    input wire [15:0] line_count // lines in window
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    sequence s_free_start;
        acq_start && !acq_stop && !armed && !frame_mode ##1 !acq_stop;
    endsequence
    sequence s_free_end;
        $fell(frame_valid) && armed && !frame_mode && !acq_stop;
    endsequence
    a_idle_unarmed: assert property (!armed && !$past(armed) |-> !frame_valid)
        else $error("window open while disarmed");
    a_start_arms: assert property (acq_start && !acq_stop |=> armed)
        else $error("start did not arm");
    a_armed_holds: assert property (armed && !acq_stop |=> armed)
        else $error("armed dropped without stop");
    a_stop_disarms: assert property (acq_stop |=> !armed ##1 !frame_valid)
        else $error("stop did not disarm");
    a_line_in_window: assert property (line_start |-> $past(frame_valid))
        else $error("line start outside window");
    a_free_opens: assert property (s_free_start |=> frame_valid)
        else $error("internal window not opened");
    a_free_reopen: assert property (s_free_end |-> ##[1:3] (frame_valid || !armed))
        else $error("internal window not reopened");
    a_close_pulses: assert property ($fell(frame_valid) |-> frame_done)
        else $error("window closed without done");
    a_free_count: assert property (frame_valid && !frame_mode && !acq_stop && !line_start
        && !$past(line_start) && line_count + 16'h0001 < height |=> frame_valid)
        else $error("window closed before height lines");
    a_done_single: assert property (frame_done |=> !frame_done)
        else $error("done pulse too long");
endmodule // lst_trigger_monitor
bind lst_trigger_ctrl lst_trigger_monitor u_mon (.core_clk, .rst_n, .acq_start, .acq_stop, .trig_wr,
    .trig_selector, .wr_mode, .wr_source, .external_trigger_input_a, .external_trigger_input_b, .wr_activation,
    .height, .line_period, .min_line_period, .armed, .frame_valid, .line_start, .frame_done, .frame_mode,
    .line_mode, .line_count);

//--- lst_trigger_ctrl_test.sv
// Purpose: self-checking bench for the trigger sequencer
// Assumes: 250 MHz clock, 250-cycle pin filter
// Notes: line count per window checked at frame_done while an expected count is queued
`timescale 1ns/1ns
`include "lst_defs.vh"
module lst_trigger_ctrl_test;
    reg core_clk, rst_n, acq_start, acq_stop, trig_wr, trig_selector, wr_mode, wr_source;
    reg [2:0] wr_activation;
    reg [15:0] height;
    reg [31:0] line_period, min_line_period;
    wire external_trigger_input_a, external_trigger_input_b, armed, frame_valid, line_start;
    wire frame_done, frame_mode, line_mode;
    wire [15:0] line_count;
    integer error_cnt = 0, num_checks = 0, seed = 32'h9290FB14, lines = 0, i, n, gmin;
    time t0;
    reg [15:0] exp_q[$];
    lst_trigger_ctrl u_dut (.core_clk, .rst_n, .external_trigger_input_a, .external_trigger_input_b, .acq_start,
        .acq_stop, .trig_wr, .trig_selector, .wr_mode, .wr_source, .wr_activation, .height, .line_period,
        .min_line_period, .armed, .frame_valid, .line_start, .frame_done, .frame_mode, .line_mode, .line_count);
    lst_pin_src u_src (.core_clk, .pin_a(external_trigger_input_a), .pin_b(external_trigger_input_b));
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    task check(input [31:0] seen, input [31:0] exp);
        begin
            num_checks = num_checks + 1;
            if (seen !== exp) begin
                error_cnt = error_cnt + 1;
                $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    task report_and_stop;
        begin
            $display("checks=%0d errors=%0d", num_checks, error_cnt);
            if (error_cnt == 0 && num_checks > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    task cmd(input stop);
        begin
            @(negedge core_clk);
            acq_start = !stop;
            acq_stop = stop;
            @(negedge core_clk);
            {acq_start, acq_stop} = 2'h0;
        end
    endtask
    task wr(input sel, input [2:0] act);
        begin
            @(negedge core_clk);
            {trig_selector, wr_mode, wr_source, wr_activation, trig_wr} = {sel, 1'b1, sel, act, 1'b1};
            @(negedge core_clk);
            trig_wr = 1'b0;
        end
    endtask
    task tog(input sel, input integer k);
        repeat (k) u_src.drive(sel, sel ? ~external_trigger_input_b : ~external_trigger_input_a,
            260 + ($random(seed) & 63));
    endtask
    task gap_min;
        begin
            gmin = 1000000;
            @(posedge line_start);
            t0 = $time;
            repeat (4) begin
                @(posedge line_start);
                if (($time - t0) / 4 < gmin)
                    gmin = ($time - t0) / 4;
                t0 = $time;
            end
        end
    endtask
    // ********************************************
    // result watcher and main sequence
    // ********************************************
    always @(negedge core_clk) begin
        if (frame_done === 1'b1) begin
            if (exp_q.size() > 0)
                check(lines + line_start, exp_q.pop_front());
            lines = 0;
        end else if (line_start === 1'b1) begin
            lines = lines + 1;
            check(line_count, lines);
        end
    end
    initial begin
        #200000;
        error_cnt = error_cnt + 1;
        report_and_stop;
    end
    initial begin
        {rst_n, acq_start, acq_stop, trig_wr, trig_selector, wr_mode, wr_source, wr_activation} = 10'h000;
        height = 16'h0003;
        {line_period, min_line_period} = {32'h00000006, 32'h00000003};
        repeat (4) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (20) @(negedge core_clk);
        check({armed, frame_valid, frame_mode, line_mode}, 4'h0);
        for (i = 0; i < 2; i = i + 1) begin
            line_period = 4 + ($random(seed) & 7);
            min_line_period = i ? line_period + 5 : 3;
            exp_q.push_back(height);
            cmd(1'b0);
            gap_min;
            check(gmin, i ? min_line_period : line_period);
            cmd(1'b1);
            repeat (20) @(negedge core_clk);
            check({armed, frame_valid}, 2'h0);
        end
        wr(1'b1, `LST_ACT_ANY);
        check({frame_mode, line_mode}, 2'h1);
        wr(1'b0, `LST_ACT_RISE);
        check({frame_mode, line_mode}, 2'h3);
        cmd(1'b0);
        for (i = 0; i < 5; i = i + 1) begin
            wr(1'b0, i[2:0]);
            wr(1'b1, 3'(i % 3));
            if (i != 2)
                u_src.drive(1'b0, i == 1 || i == 4, 300);
            else
                tog(1'b1, 2);
            n = i < 3 ? 3 : 2;
            exp_q.push_back(n);
            tog(1'b0, 1);
            if (i == 2) begin
                u_src.drive(1'b1, ~external_trigger_input_b, 100);
                u_src.drive(1'b1, ~external_trigger_input_b, 300);
            end
            repeat (n) tog(1'b1, i == 2 ? 1 : 2);
            if (i > 2)
                tog(1'b0, 1);
            repeat (300) @(negedge core_clk);
        end
        cmd(1'b1);
        repeat (20) @(negedge core_clk);
        check(exp_q.size(), 0);
        report_and_stop;
    end
endmodule // lst_trigger_ctrl_test
